// ===== design/nbci_defs.vh
`ifndef NBCI_DEFS_VH
`define NBCI_DEFS_VH

// Operation codes on the user command port.
`define NBCI_OP_READ    3'h0
`define NBCI_OP_PROG    3'h1
`define NBCI_OP_MPROG   3'h2
`define NBCI_OP_ERASE   3'h3
`define NBCI_OP_STATUS  3'h4
`define NBCI_OP_EDC     3'h5
`define NBCI_OP_RESET   3'h6

// Command codes sent to the memory on the low byte.
`define NBCI_C_PAGE_READ_CMD    8'h00
`define NBCI_C_READ2    8'h30
`define NBCI_C_PROG1    8'h80
`define NBCI_C_CBPROG   8'h85
`define NBCI_C_PROG2    8'h10
`define NBCI_C_DUMMY    8'h11
`define NBCI_C_PLANE2   8'h81
`define NBCI_C_ERASE1   8'h60
`define NBCI_C_ERASE2   8'hd0
`define NBCI_C_STATUS   8'h70
`define NBCI_C_EDC      8'h7b
`define NBCI_C_RESET    8'hff

// Timing, in ns as specified, and cycle counts derived from the clock.
`define NBCI_CLK_NS     100
`define NBCI_T_REA_NS   30
`define NBCI_T_WB_NS    100
`define NBCI_REA_CYC ((`NBCI_T_REA_NS + `NBCI_CLK_NS - 1) / `NBCI_CLK_NS)
`define NBCI_WB_CYC  ((`NBCI_T_WB_NS + `NBCI_CLK_NS - 1) / `NBCI_CLK_NS)

// Write data buffer shape.
`define NBCI_FIFO_W     16
`define NBCI_FIFO_D     4
`define NBCI_FIFO_AW    2

`endif

// ===== design/nbci_host.v
// Function
// - Select low during operation, high idle
// - Ready/busy is pulled-up input, never driven
// - Upper byte used for data in x16
// - Five x8 address bytes, fixed layout
// - Five x16 address bytes, fixed layout
// - Unused address bits and upper lines low
// - Two-code read, program, erase sequences
// - Multi-plane program 80/85,11,81,10 order
// - Error-detect status only after copy-back
// - Read: latches low, write strobe high
// - Write mode: read strobe, protect high; protect is driven high only for program and erase ops
`timescale 1ns/1ps
`include "nbci_defs.vh"

// Small first-in first-out buffer for program data.
module nbci_fifo #(
   parameter W  = 16,
   parameter D  = 4,
   parameter AW = 2
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wp;
   reg [AW-1:0] rp;
   reg [AW:0]   cnt;
   wire         push;
   wire         pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready  = (cnt != D[AW:0]);
   assign out_valid = (cnt != {(AW+1){1'b0}});
   assign out_data  = mem[rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointers wrap naturally because the depth is a power of two.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp  <= {AW{1'b0}};
         rp  <= {AW{1'b0}};
         cnt <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wp <= wp + 1'b1;
         if (pop)
            rp <= rp + 1'b1;
         if (push & ~pop)
            cnt <= cnt + 1'b1;
         else if (pop & ~push)
            cnt <= cnt - 1'b1;
      end
   end

   // Storage carries no reset; only the pointers and the count need a defined value.
   always @(posedge clk) begin
      if (push)
         mem[wp] <= in_data;
   end
endmodule // nbci_fifo

// Host-side sequencer that drives a NAND memory through its pins.
module nbci_host (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        cmd_valid,
   output wire        cmd_ready,
   input  wire [2:0]  cmd_op,
   input  wire [28:0] cmd_addr,
   input  wire [28:0] cmd_addr2,
   input  wire [11:0] cmd_len,
   input  wire        cmd_copyback,
   input  wire        bus_x16,
   output reg         cmd_done,
   output reg         cmd_err,
   input  wire        wr_valid,
   output wire        wr_ready,
   input  wire [15:0] wr_data,
   output reg         rd_valid,
   output reg  [15:0] rd_data,
   output reg         ce_n,
   output reg         cle,
   output reg         ale,
   output reg         we_n,
   output reg         read_strobe_n,
   output reg         wp_n,
   output reg  [15:0] io_out,
   output reg         io_oe,
   input  wire [15:0] io_in,
   input  wire        rb_in
);
   localparam S_IDLE = 1'b0;
   localparam S_RUN  = 1'b1;
   localparam K_CMD  = 3'h0;
   localparam K_ADDR = 3'h1;
   localparam K_WDAT = 3'h2;
   localparam K_WAIT = 3'h3;
   localparam K_RDAT = 3'h4;
   localparam K_END  = 3'h5;
   // Sums are formed at full width, then cut to the counter on purpose.
   localparam integer REA_SUM  = `NBCI_REA_CYC + 2;
   localparam integer WB_SUM   = `NBCI_WB_CYC + 2;
   localparam [3:0]   REA_WAIT = REA_SUM[3:0];
   localparam [3:0]   WB_WAIT  = WB_SUM[3:0];

   reg        st;
   reg        ph;
   reg [3:0]  stg;
   reg [2:0]  op;
   reg [28:0] addr;
   reg [28:0] addr2;
   reg [11:0] len;
   reg        cb;
   reg        x16;
   reg        cb_seen;
   reg [11:0] cnt;
   reg [2:0]  idx;
   reg [3:0]  tcnt;
   reg [15:0] io_m;
   reg [15:0] io_s;
   reg        rb_m;
   reg        rb_s;
   reg [2:0]  kind;
   reg [7:0]  code;
   reg        sel2;
   reg [7:0]  abyte;
   wire [28:0] a;
   wire [2:0]  bidx;
   wire [2:0]  blast;
   wire [11:0] lim;
   wire        f_valid;
   wire        f_ready;
   wire [15:0] f_data;
   wire        modify;

   // Pins from the memory pass two flops before any logic sees them.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_m <= 16'h0000;
         io_s <= 16'h0000;
         rb_m <= 1'b0;
         rb_s <= 1'b0;
      end else begin
         io_m <= io_in;
         io_s <= io_m;
         rb_m <= rb_in;
         rb_s <= rb_m;
      end
   end

   nbci_fifo #(
      .W  (`NBCI_FIFO_W),
      .D  (`NBCI_FIFO_D),
      .AW (`NBCI_FIFO_AW)
   ) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // Busy memory accepts only reset and status, so others wait here.
   assign cmd_ready = (st == S_IDLE) &
                      (rb_s | (cmd_op == `NBCI_OP_STATUS) |
                       (cmd_op == `NBCI_OP_RESET));
   assign modify = (cmd_op == `NBCI_OP_PROG) |
                   (cmd_op == `NBCI_OP_MPROG) |
                   (cmd_op == `NBCI_OP_ERASE);
   assign f_ready = (st == S_RUN) & (kind == K_WDAT) & ~ph & (cnt != len);

   // Step table: what each operation sends at each stage.
   always @* begin
      kind = K_END;
      code = `NBCI_C_RESET;
      sel2 = 1'b0;
      case (op)
         `NBCI_OP_READ: begin
            case (stg)
               4'h0: begin kind = K_CMD; code = `NBCI_C_PAGE_READ_CMD; end
               4'h1: kind = K_ADDR;
               4'h2: begin kind = K_CMD; code = `NBCI_C_READ2; end
               4'h3: kind = K_WAIT;
               4'h4: kind = K_RDAT;
               default: kind = K_END;
            endcase
         end
         `NBCI_OP_PROG, `NBCI_OP_MPROG: begin
            case (stg)
               4'h0: begin
                  kind = K_CMD;
                  code = cb ? `NBCI_C_CBPROG : `NBCI_C_PROG1;
               end
               4'h1: kind = K_ADDR;
               4'h2: kind = K_WDAT;
               4'h3: begin
                  kind = K_CMD;
                  code = (op == `NBCI_OP_MPROG) ? `NBCI_C_DUMMY
                                                : `NBCI_C_PROG2;
               end
               4'h4: kind = K_WAIT;
               4'h5: begin
                  kind = (op == `NBCI_OP_MPROG) ? K_CMD : K_END;
                  code = `NBCI_C_PLANE2;
               end
               4'h6: begin kind = K_ADDR; sel2 = 1'b1; end
               4'h7: kind = K_WDAT;
               4'h8: begin kind = K_CMD; code = `NBCI_C_PROG2; end
               4'h9: kind = K_WAIT;
               default: kind = K_END;
            endcase
         end
         `NBCI_OP_ERASE: begin
            case (stg)
               4'h0: begin kind = K_CMD; code = `NBCI_C_ERASE1; end
               4'h1: kind = K_ADDR;
               4'h2: begin kind = K_CMD; code = `NBCI_C_ERASE2; end
               4'h3: kind = K_WAIT;
               default: kind = K_END;
            endcase
         end
         `NBCI_OP_STATUS, `NBCI_OP_EDC: begin
            case (stg)
               4'h0: begin
                  kind = K_CMD;
                  code = (op == `NBCI_OP_EDC) ? `NBCI_C_EDC
                                              : `NBCI_C_STATUS;
               end
               4'h1: kind = K_RDAT;
               default: kind = K_END;
            endcase
         end
         `NBCI_OP_RESET: begin
            case (stg)
               4'h0: kind = K_CMD;
               4'h1: kind = K_WAIT;
               default: kind = K_END;
            endcase
         end
         default: kind = K_END;
      endcase
   end

   // Erase sends only the three row bytes; zeros fill unused bits.
   assign a     = sel2 ? addr2 : addr;
   assign bidx  = (op == `NBCI_OP_ERASE) ? idx + 3'h2 : idx;
   assign blast = (op == `NBCI_OP_ERASE) ? 3'h2 : 3'h4;
   assign lim   = ((op == `NBCI_OP_STATUS) | (op == `NBCI_OP_EDC)) ?
                  12'h001 : len;
   always @* begin
      abyte = 8'h00;
      case (bidx)
         3'h0: abyte = a[7:0];
         3'h1: abyte = x16 ? {5'h00, a[10:8]} : {4'h0, a[11:8]};
         3'h2: abyte = x16 ? a[18:11] : a[19:12];
         3'h3: abyte = x16 ? a[26:19] : a[27:20];
         3'h4: abyte = x16 ? {7'h00, a[27]} : {7'h00, a[28]};
         default: abyte = 8'h00;
      endcase
   end

   // Main sequencer; every strobe phase lasts at least one clock.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= S_IDLE; ph <= 1'b0; stg <= 4'h0; op <= `NBCI_OP_RESET;
         addr <= 29'h0; addr2 <= 29'h0; len <= 12'h000; cb <= 1'b0;
         x16 <= 1'b0; cb_seen <= 1'b0; cnt <= 12'h000; idx <= 3'h0;
         tcnt <= 4'h0; cmd_done <= 1'b0; cmd_err <= 1'b0;
         rd_valid <= 1'b0; rd_data <= 16'h0000; ce_n <= 1'b1;
         cle <= 1'b0; ale <= 1'b0; we_n <= 1'b1; read_strobe_n <= 1'b1;
         wp_n <= 1'b0; io_out <= 16'h0000; io_oe <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         cmd_err  <= 1'b0;
         rd_valid <= 1'b0;
         case (st)
            S_IDLE: begin
               if (cmd_valid & cmd_ready) begin
                  if ((cmd_op == 3'h7) |
                      ((cmd_op == `NBCI_OP_EDC) & ~cb_seen)) begin
                     cmd_err <= 1'b1;
                  end else begin
                     op <= cmd_op; addr <= cmd_addr; addr2 <= cmd_addr2;
                     len <= cmd_len; cb <= cmd_copyback; x16 <= bus_x16;
                     stg <= 4'h0; ph <= 1'b0; cnt <= 12'h000;
                     idx <= 3'h0; tcnt <= 4'h0;
                     ce_n <= 1'b0;
                     wp_n <= modify;
                     st <= S_RUN;
                  end
               end
            end
            S_RUN: begin
               case (kind)
                  K_CMD, K_ADDR: begin
                     if (!ph) begin
                        cle <= (kind == K_CMD);
                        ale <= (kind == K_ADDR);
                        io_out <= {8'h00, (kind == K_CMD) ? code
                                                          : abyte};
                        io_oe <= 1'b1;
                        we_n <= 1'b0;
                        ph <= 1'b1;
                     end else begin
                        we_n <= 1'b1;
                        ph <= 1'b0;
                        if ((kind == K_CMD) | (idx == blast)) begin
                           idx <= 3'h0;
                           stg <= stg + 4'h1;
                        end else
                           idx <= idx + 3'h1;
                     end
                  end
                  K_WDAT: begin
                     if (!ph) begin
                        cle <= 1'b0;
                        ale <= 1'b0;
                        if (cnt == len) begin
                           cnt <= 12'h000;
                           stg <= stg + 4'h1;
                        end else if (f_valid) begin
                           io_out <= x16 ? f_data
                                         : {8'h00, f_data[7:0]};
                           io_oe <= 1'b1;
                           we_n <= 1'b0;
                           ph <= 1'b1;
                        end
                     end else begin
                        we_n <= 1'b1;
                        ph <= 1'b0;
                        cnt <= cnt + 12'h001;
                     end
                  end
                  K_WAIT: begin
                     cle <= 1'b0; ale <= 1'b0; io_oe <= 1'b0;
                     if (tcnt != WB_WAIT)
                        tcnt <= tcnt + 4'h1;
                     else if (rb_s) begin
                        tcnt <= 4'h0;
                        stg <= stg + 4'h1;
                     end
                  end
                  K_RDAT: begin
                     cle <= 1'b0; ale <= 1'b0; io_oe <= 1'b0;
                     if (!ph) begin
                        if (cnt == lim) begin
                           cnt <= 12'h000;
                           stg <= stg + 4'h1;
                        end else begin
                           read_strobe_n <= 1'b0;
                           tcnt <= 4'h0;
                           ph <= 1'b1;
                        end
                     end else if (tcnt != REA_WAIT) begin
                        tcnt <= tcnt + 4'h1;
                     end else begin
                        rd_data <= x16 ? io_s : {8'h00, io_s[7:0]};
                        rd_valid <= 1'b1;
                        read_strobe_n <= 1'b1;
                        cnt <= cnt + 12'h001;
                        ph <= 1'b0;
                     end
                  end
                  default: begin
                     cle <= 1'b0; ale <= 1'b0; io_oe <= 1'b0;
                     ce_n <= 1'b1;
                     wp_n <= 1'b0;
                     if ((op == `NBCI_OP_PROG) | (op == `NBCI_OP_MPROG))
                        cb_seen <= cb;
                     cmd_done <= 1'b1;
                     st <= S_IDLE;
                  end
               endcase
            end
            default: st <= S_IDLE;
         endcase
      end
   end
endmodule // nbci_host

// ===== dv/nbci_flash_model.sv
`timescale 1ns/1ps
module nbci_flash_model (
   input  wire        ce_n,
   input  wire        cle,
   input  wire        ale,
   input  wire        we_n,
   input  wire        read_strobe_n,
   input  wire        wp_n,
   input  wire [15:0] io_out,
   input  wire        io_oe,
   output wire [15:0] io_in,
   output reg         rb_low
);
   parameter read_access_delay = 30;
   reg [17:0] ev [0:255];
   reg [15:0] dout = 16'h0000;
   reg [7:0]  cmd = 8'hff;
   reg [7:0]  col = 8'h00;
   reg        first = 1'b0;
   reg        cb = 1'b0;
   integer    nev = 0;
   integer    busy_ns = 2000;

   initial rb_low = 1'b0;

   // Off the bus the lines show the inverse of the last word, so a stale
   // sample can never pass for fresh data.
   assign io_in = io_oe ? io_out :
      (!ce_n && !read_strobe_n) ? dout : ~dout;

   // Open drain pulled low for a span; the release is scheduled ahead.
   task busy(input integer t);
      begin
         rb_low = 1'b1;
         rb_low <= #(t) 1'b0;
      end
   endtask

   // Bus values are latched at the rising write strobe while selected.
   always @(posedge we_n) begin
      if (!ce_n && (!rb_low || !cle || io_out[7:0] == 8'hff ||
            io_out[7:0] == 8'h70)) begin
         ev[nev] = {cle ? 2'd1 : ale ? 2'd2 : 2'd3, io_out};
         nev = nev + 1;
         if (cle) begin
            cmd = io_out[7:0];
            first = 1'b1;
            if (cmd == 8'h85 || cmd == 8'h80) cb = cmd[2];
            case (cmd)
               8'h30, 8'hff: busy(busy_ns);
               8'h10, 8'hd0: if (wp_n) busy(busy_ns);
               8'h11: if (wp_n) busy(busy_ns / 4);
               default: ;
            endcase
         end else if (ale && first) begin
            col = io_out[7:0];
            first = 1'b0;
         end
      end
   end

   // Each fall of the read strobe presents one word and moves the column on.
   always @(negedge read_strobe_n) begin
      if (!ce_n) begin
         dout <= #(read_access_delay) (cmd == 8'h70) ? 16'h00e0 :
            (cmd == 8'h7b && cb) ? 16'h0001 : {~col, col};
         col = col + 8'h01;
      end
   end
endmodule // nbci_flash_model

// ===== dv/nbci_host_assertions.sv
`timescale 1ns/1ps
module nbci_host_assertions (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        cmd_valid,
   input wire        cmd_ready,
   input wire [2:0]  cmd_op,
   input wire        cmd_done,
   input wire        cmd_err,
   input wire        rd_valid,
   input wire        ce_n,
   input wire        cle,
   input wire        ale,
   input wire        we_n,
   input wire        read_strobe_n,
   input wire        wp_n,
   input wire [15:0] io_out,
   input wire        io_oe,
   input wire        rb_in
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // An accepted request that really reaches the pins.
   wire take = cmd_valid && cmd_ready && cmd_op != 3'h5 && cmd_op != 3'h7;

   // Write cycle: strobe low one cycle, then high with the bus still held.
   sequence s_wcyc;
      !we_n && read_strobe_n && io_oe ##1
      we_n && io_oe && $stable(io_out) && $stable(cle) && $stable(ale);
   endsequence
   // Read word: strobe low four cycles, then high with the word handed on.
   sequence s_rword;
      !read_strobe_n [*4] ##1 (read_strobe_n && rd_valid);
   endsequence

   a_write_cycle: assert property ($fell(we_n) |-> s_wcyc)
      else $error("write cycle malformed");
   a_read_word: assert property ($fell(read_strobe_n) |-> s_rword)
      else $error("read strobe length wrong");
   a_read_pins: assert property (!read_strobe_n |->
      we_n && !cle && !ale && !ce_n && !io_oe)
      else $error("pins wrong during read");
   a_latch_excl: assert property (cle |-> !ale)
      else $error("both latch strobes high");
   a_upper_low: assert property (io_oe && (cle || ale) |->
      io_out[15:8] == 8'h00)
      else $error("upper lines not low");
   a_data_protect: assert property (!we_n && !cle && !ale |-> wp_n)
      else $error("data written while protected");
   a_select_take: assert property (take |=> !ce_n)
      else $error("not selected after accept");
   a_protect_kind: assert property (take |=>
      wp_n == ($past(cmd_op) inside {3'h1, 3'h2, 3'h3}))
      else $error("write protect level wrong");
   a_done_idle: assert property (cmd_done |-> ce_n && !io_oe)
      else $error("still selected at done");
   a_refuse_err: assert property (cmd_valid && cmd_ready &&
      cmd_op == 3'h7 |=> cmd_err && ce_n)
      else $error("illegal op not refused");
   a_busy_gate: assert property (cmd_valid && cmd_ready &&
      cmd_op < 3'h4 |-> $past(rb_in, 2))
      else $error("op taken while busy");
endmodule // nbci_host_assertions

// ===== dv/nbci_host_tb.sv
`timescale 1ns/1ps
module nbci_host_tb;
   reg         sys_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         cmd_valid = 1'b0, cmd_copyback = 1'b0, bus_x16 = 1'b0;
   reg  [2:0]  cmd_op = 3'h0;
   reg  [28:0] cmd_addr = 29'h0, cmd_addr2 = 29'h0;
   reg  [11:0] cmd_len = 12'h000;
   reg         wr_valid = 1'b0, got_err = 1'b0;
   reg  [15:0] wr_data = 16'h0000;
   wire        cmd_ready, cmd_done, cmd_err, wr_ready, rd_valid, rb_in;
   wire        ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, rb_low;
   wire [15:0] rd_data, io_out, io_in;
   reg  [17:0] eq [$];
   reg  [15:0] rq [$];
   integer     mismatches = 0, n_compared = 0, s = 0;

   // The ready line only becomes a level through this pull-up.
   assign rb_in = rb_low ? 1'b0 : 1'b1;
   always #50 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);

   nbci_host nbci_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_addr2(cmd_addr2), .cmd_len(cmd_len),
      .cmd_copyback(cmd_copyback), .bus_x16(bus_x16),
      .cmd_done(cmd_done), .cmd_err(cmd_err), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in), .rb_in(rb_in));
   nbci_flash_model mem (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in), .rb_low(rb_low));

   task chk_ev(input [17:0] x, input [17:0] g);
      begin
         n_compared++;
         if (g !== x) begin
            mismatches++;
            $display("[FAIL] %0t bus event exp %h got %h", $time, x, g);
         end
      end
   endtask
   task chk_word(input [15:0] x, input [15:0] g);
      begin
         n_compared++;
         if (g !== x) begin
            mismatches++;
            $display("[FAIL] %0t word exp %h got %h", $time, x, g);
         end
      end
   endtask
   // A handshake that never completes is itself a mismatch.
   task lim_out(input integer k, input integer n);
      if (k >= n) begin
         mismatches++;
         $display("[FAIL] %0t handshake limit reached", $time);
      end
   endtask
   task e(input [1:0] k, input [15:0] v);
      eq.push_back({k, v});
   endtask
   // Expected address bytes; erase sends only the three row bytes.
   task ea(input [28:0] a, input w, input er);
      reg [7:0] b [0:4];
      integer i;
      begin
         b[0] = a[7:0];
         b[1] = w ? {5'h00, a[10:8]} : {4'h0, a[11:8]};
         b[2] = w ? a[18:11] : a[19:12];
         b[3] = w ? a[26:19] : a[27:20];
         b[4] = {7'h00, w ? a[27] : a[28]};
         for (i = er ? 2 : 0; i < 5; i++) e(2'd2, {8'h00, b[i]});
      end
   endtask
   task log_ok;
      integer i;
      begin
         chk_ev(18'(eq.size()), 18'(mem.nev - s));
         for (i = 0; i < eq.size(); i++) chk_ev(eq[i], mem.ev[s + i]);
         eq.delete();
      end
   endtask
   task op(input [2:0] o, input [28:0] a, input [11:0] n, input c, input w);
      integer k;
      begin
         s = mem.nev;
         rq.delete();
         @(negedge sys_clk);
         cmd_op = o;
         cmd_addr = a;
         cmd_addr2 = a ^ 29'h0004_0000;
         cmd_len = n;
         cmd_copyback = c;
         bus_x16 = w;
         cmd_valid = 1'b1;
         for (k = 0; cmd_ready !== 1'b1 && k < 999; k++) @(negedge sys_clk);
         lim_out(k, 999);
         @(negedge sys_clk);
         cmd_valid = 1'b0;
         for (k = 0; (cmd_done | cmd_err) !== 1'b1 && k < 9999; k++)
            @(negedge sys_clk);
         lim_out(k, 9999);
         got_err = cmd_err;
      end
   endtask
   task push(input integer n, input [15:0] b);
      integer i, k;
      begin
         for (i = 0; i < n; i++) begin
            @(negedge sys_clk);
            wr_valid = 1'b1;
            wr_data = b + i[15:0];
            for (k = 0; wr_ready !== 1'b1 && k < 999; k++) @(negedge sys_clk);
            lim_out(k, 999);
         end
         @(negedge sys_clk);
         wr_valid = 1'b0;
      end
   endtask

   task t_read(input w);
      integer i;
      reg [7:0] c;
      begin
         e(2'd1, 16'h0000);
         ea(29'h1bcd_ef03, w, 1'b0);
         e(2'd1, 16'h0030);
         op(3'h0, 29'h1bcd_ef03, 12'h003, 1'b0, w);
         log_ok;
         chk_word(16'h0003, 16'(rq.size()));
         for (i = 0; i < 3; i++) begin
            c = 8'h03 + i[7:0];
            chk_word(w ? {~c, c} : {8'h00, c}, rq[i]);
         end
      end
   endtask
   task t_mprog;
      begin
         e(2'd1, 16'h0085);
         ea(29'h0000_1204, 1'b1, 1'b0);
         e(2'd3, 16'ha5c3);
         e(2'd1, 16'h0011);
         e(2'd1, 16'h0081);
         ea(29'h0004_1204, 1'b1, 1'b0);
         e(2'd3, 16'ha5c4);
         e(2'd1, 16'h0010);
         fork
            op(3'h2, 29'h0000_1204, 12'h001, 1'b1, 1'b1);
            push(2, 16'ha5c3);
         join
         log_ok;
         e(2'd1, 16'h007b);
         op(3'h5, 29'h0, 12'h000, 1'b0, 1'b1);
         log_ok;
         chk_word(16'h0001, rq[0]);
      end
   endtask
   // Fill the buffer before the request so the sequencer meets a full one.
   task t_prog;
      integer i;
      begin
         push(4, 16'h0040);
         chk_word(16'h0000, {15'h0000, wr_ready});
         e(2'd1, 16'h0080);
         ea(29'h0a0b_0c0d, 1'b0, 1'b0);
         for (i = 0; i < 6; i++) e(2'd3, 16'h0040 + i[15:0]);
         e(2'd1, 16'h0010);
         fork
            op(3'h1, 29'h0a0b_0c0d, 12'h006, 1'b0, 1'b0);
            push(2, 16'h0044);
         join
         log_ok;
      end
   endtask
   task t_refuse;
      begin
         op(3'h7, 29'h0, 12'h000, 1'b0, 1'b0);
         chk_word(16'h0001, {15'h0000, got_err});
         chk_word(16'h0000, 16'(mem.nev - s));
         op(3'h5, 29'h0, 12'h000, 1'b0, 1'b0);
         chk_word(16'h0001, {15'h0000, got_err});
         chk_word(16'h0000, 16'(mem.nev - s));
      end
   endtask
   task t_erase;
      begin
         e(2'd1, 16'h0060);
         ea(29'h1234_5678, 1'b0, 1'b1);
         e(2'd1, 16'h00d0);
         op(3'h3, 29'h1234_5678, 12'h000, 1'b0, 1'b0);
         log_ok;
         e(2'd1, 16'h0070);
         op(3'h4, 29'h0, 12'h000, 1'b0, 1'b0);
         log_ok;
         chk_word(16'h00e0, rq[0]);
         e(2'd1, 16'h00ff);
         op(3'h6, 29'h0, 12'h000, 1'b0, 1'b0);
         log_ok;
      end
   endtask
   // Status must pass a busy memory while array operations stall.
   task t_busy;
      begin
         @(negedge sys_clk);
         mem.busy(3000);
         e(2'd1, 16'h0070);
         op(3'h4, 29'h0, 12'h000, 1'b0, 1'b0);
         log_ok;
         chk_word(16'h00e0, rq[0]);
         cmd_op = 3'h0;
         @(negedge sys_clk);
         chk_word(16'h0000, {15'h0000, cmd_ready});
      end
   endtask

   task test_done;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // Busy spans are 2 us, 0.5 us after 11h and 3 us in t_busy; 3 ms leaves ample room for a slow run.
   initial begin
      #3000000;
      mismatches = mismatches + 1;
      test_done;
   end
   initial begin
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      t_read(1'b0);
      t_read(1'b1);
      t_mprog;
      t_prog;
      t_refuse;
      t_erase;
      t_busy;
      test_done;
   end
endmodule // nbci_host_tb

bind nbci_host nbci_host_assertions nbci_host_assertions_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_done(cmd_done),
   .cmd_err(cmd_err), .rd_valid(rd_valid), .ce_n(ce_n), .cle(cle),
   .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
   .io_out(io_out), .io_oe(io_oe), .rb_in(rb_in));
